// File: logic/dicu_regs.svh
// Register indices, field positions and reset values of the capture unit.
// Assumes byte address = 4 * index on a 32-bit AXI4-Lite slave port.
`ifndef DICU_REGS_SVH
`define DICU_REGS_SVH

`define DICU_IDX_CSS 8'h56
`define DICU_IDX_PRIO 8'h57
`define DICU_IDX_TRIG1 8'h58
`define DICU_IDX_SRC1 8'h59
`define DICU_IDX_CNTL1 8'h5a
`define DICU_IDX_CNTH1 8'h5b
`define DICU_IDX_TRIG2 8'h5c
`define DICU_IDX_SRC2 8'h5d
`define DICU_IDX_CNTL2 8'h5e
`define DICU_IDX_CNTH2 8'h5f
`define DICU_IDX_PRESC 8'h60

// Control/status: read flags, write enables and counter resets
`define DICU_CSS_START2 7
`define DICU_CSS_STOP2 6
`define DICU_CSS_START1 5
`define DICU_CSS_STOP1 4
`define DICU_CSS_ROLL2 3
`define DICU_CSS_ROLL1 2
`define DICU_CSS_CLR2 1
`define DICU_CSS_CLR1 0
`define DICU_CSS_RST 8'h00
`define DICU_PRIO_RST 2'h0
`define DICU_TRIG_RST 8'h00
`define DICU_PRESC_RST 8'h00

// Trigger config fields
`define DICU_TRIG_MODE_HI 7
`define DICU_TRIG_MODE_LO 6
`define DICU_TRIG_STARTE_HI 5
`define DICU_TRIG_STARTE_LO 4
`define DICU_TRIG_STOPE_HI 3
`define DICU_TRIG_STOPE_LO 2
`define DICU_TRIG_LATST 1
`define DICU_TRIG_LATSP 0

`define DICU_RESP_OKAY 2'h0
`define DICU_RESP_SLVERR 2'h2

`endif

// File: logic/dicu_pkg.sv
// Types shared by the capture unit.
// Assumes dicu_regs.svh for the numeric constants.
package dicu_pkg;
    // Counter run modes, in trigger config field order
    typedef enum logic [1:0] {
        DICU_MODE_OFF,
        DICU_MODE_FREE,
        DICU_MODE_UNTIL_STOP,
        DICU_MODE_START_STOP
    } dicu_mode_e;

    // Edge selection, in trigger config field order
    typedef enum logic [1:0] {
        DICU_EDGE_NONE,
        DICU_EDGE_RISE,
        DICU_EDGE_FALL,
        DICU_EDGE_BOTH
    } dicu_edge_e;

    typedef logic [15:0] dicu_count_t;
endpackage : dicu_pkg

// File: logic/dicu_top.sv
// Two-channel input capture unit with an AXI4-Lite register slave.
// Assumes capture pins asynchronous to aclk; aclk is the peripheral clock.
`include "dicu_regs.svh"

module dicu_top #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] capture_pins,
    output logic capture_irq_req,
    output logic [1:0] capture_irq_level,
    output logic capture_tick,
    output dicu_pkg::dicu_count_t chan1_count,
    output dicu_pkg::dicu_count_t chan2_count
);
    import dicu_pkg::*;

    // =========================================================
    // Functions
    // =========================================================
    function automatic logic edge_hit(input logic prev, input logic cur,
                                      input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        case (dicu_edge_e'(sel))
            DICU_EDGE_RISE: hit = !prev && cur;
            DICU_EDGE_FALL: hit = prev && !cur;
            DICU_EDGE_BOTH: hit = prev != cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
        return addr[9:2];
    endfunction : reg_index

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        return addr[1:0] == 2'h0 && addr[ADDR_W-1:10] == '0
            && idx >= `DICU_IDX_CSS && idx <= `DICU_IDX_PRESC;
    endfunction : reg_mapped

    // =========================================================
    // Registers
    // =========================================================
    logic [7:0] trig_r [2];
    logic [7:0] src_r [2];
    logic [5:0] irq_en_r;
    logic [1:0] prio_r;
    logic [7:0] presc_r;
    logic [8:0] presc_cnt_r;
    logic tick;
    logic [15:0] pin_s1_r;
    logic [15:0] pin_s2_r;
    logic start_prev_r [2];
    logic stop_prev_r [2];
    logic start_ev [2];
    logic stop_ev [2];
    logic roll_ev [2];
    logic cap_ev [2];
    logic sw_clr [2];
    logic run_r [2];
    dicu_count_t count_r [2];
    dicu_count_t latch_r [2];
    logic [7:0] hi_shadow_r [2];
    logic start_flag_r [2];
    logic stop_flag_r [2];
    logic roll_flag_r [2];
    logic irq_pend_r;
    logic irq_set;
    logic css_rd;
    logic lo_rd [2];

    // AXI state
    logic [ADDR_W-1:0] awaddr_r;
    logic aw_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic wr_byte;

    // =========================================================
    // AXI4-Lite slave
    // =========================================================
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign wr_en = aw_have_r && w_have_r && !bvalid_r;
    assign rd_en = s_axi_arvalid && !rvalid_r;
    assign wr_idx = reg_index(awaddr_r);
    assign rd_idx = reg_index(s_axi_araddr);
    assign wr_byte = wr_en && reg_mapped(awaddr_r) && wstrb_r[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            awaddr_r <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
        else if (wr_en)
        begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        else if (wr_en)
        begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= `DICU_RESP_OKAY;
        end
        else if (wr_en)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= reg_mapped(awaddr_r) ? `DICU_RESP_OKAY : `DICU_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data; write-only registers read as zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `DICU_RESP_OKAY;
        end
        else if (rd_en)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= reg_mapped(s_axi_araddr) ? `DICU_RESP_OKAY : `DICU_RESP_SLVERR;
            rdata_r <= 32'h0000_0000;
            if (reg_mapped(s_axi_araddr))
            begin
                case (rd_idx)
                    `DICU_IDX_CSS: rdata_r[7:0] <= {start_flag_r[1], stop_flag_r[1],
                        start_flag_r[0], stop_flag_r[0], roll_flag_r[1],
                        roll_flag_r[0], 2'h0};
                    `DICU_IDX_CNTL1: rdata_r[7:0] <= latch_r[0][7:0];
                    `DICU_IDX_CNTH1: rdata_r[7:0] <= hi_shadow_r[0];
                    `DICU_IDX_CNTL2: rdata_r[7:0] <= latch_r[1][7:0];
                    `DICU_IDX_CNTH2: rdata_r[7:0] <= hi_shadow_r[1];
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
        else if (s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign css_rd = rd_en && reg_mapped(s_axi_araddr) && rd_idx == `DICU_IDX_CSS;
    assign lo_rd[0] = rd_en && reg_mapped(s_axi_araddr) && rd_idx == `DICU_IDX_CNTL1;
    assign lo_rd[1] = rd_en && reg_mapped(s_axi_araddr) && rd_idx == `DICU_IDX_CNTL2;

    // =========================================================
    // Configuration registers
    // =========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_en_r <= 6'(`DICU_CSS_RST);
            prio_r <= `DICU_PRIO_RST;
            trig_r[0] <= `DICU_TRIG_RST;
            trig_r[1] <= `DICU_TRIG_RST;
            presc_r <= `DICU_PRESC_RST;
        end
        else if (wr_byte)
        begin
            case (wr_idx)
                `DICU_IDX_CSS: irq_en_r <= wdata_r[7:2];
                `DICU_IDX_PRIO: prio_r <= wdata_r[1:0];
                `DICU_IDX_TRIG1: trig_r[0] <= wdata_r[7:0];
                `DICU_IDX_TRIG2: trig_r[1] <= wdata_r[7:0];
                `DICU_IDX_PRESC: presc_r <= wdata_r[7:0];
                default: presc_r <= presc_r;
            endcase
        end
    end

    // Source selects have no reset value
    always_ff @(posedge aclk)
    begin
        if (wr_byte && wr_idx == `DICU_IDX_SRC1)
        begin
            src_r[0] <= wdata_r[7:0];
        end
        if (wr_byte && wr_idx == `DICU_IDX_SRC2)
        begin
            src_r[1] <= wdata_r[7:0];
        end
    end

    assign sw_clr[0] = wr_byte && wr_idx == `DICU_IDX_CSS && wdata_r[`DICU_CSS_CLR1];
    assign sw_clr[1] = wr_byte && wr_idx == `DICU_IDX_CSS && wdata_r[`DICU_CSS_CLR2];

    // =========================================================
    // Prescaler: one tick every 2*(presc_r+1) clocks
    // =========================================================
    assign tick = presc_cnt_r == {presc_r, 1'b1};
    assign capture_tick = tick;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            presc_cnt_r <= 9'h000;
        end
        else if (tick || presc_cnt_r > {presc_r, 1'b1})
        begin
            presc_cnt_r <= 9'h000;
        end
        else
        begin
            presc_cnt_r <= presc_cnt_r + 9'h001;
        end
    end

    // =========================================================
    // Pin synchroniser and sampling on the counting clock
    // =========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_r <= 16'h0000;
            pin_s2_r <= 16'h0000;
        end
        else
        begin
            pin_s1_r <= capture_pins;
            pin_s2_r <= pin_s1_r;
        end
    end

    // =========================================================
    // Channels
    // =========================================================
    always_comb
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            start_ev[ch] = tick && edge_hit(start_prev_r[ch], pin_s2_r[src_r[ch][7:4]],
                trig_r[ch][`DICU_TRIG_STARTE_HI:`DICU_TRIG_STARTE_LO]);
            stop_ev[ch] = tick && edge_hit(stop_prev_r[ch], pin_s2_r[src_r[ch][3:0]],
                trig_r[ch][`DICU_TRIG_STOPE_HI:`DICU_TRIG_STOPE_LO]);
            roll_ev[ch] = tick && run_r[ch] && !sw_clr[ch] && count_r[ch] == 16'hffff;
            cap_ev[ch] = (start_ev[ch] && trig_r[ch][`DICU_TRIG_LATST])
                || (stop_ev[ch] && trig_r[ch][`DICU_TRIG_LATSP]);
        end
    end

    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!aresetn)
            begin
                start_prev_r[ch] <= 1'b0;
                stop_prev_r[ch] <= 1'b0;
            end
            else if (tick)
            begin
                start_prev_r[ch] <= pin_s2_r[src_r[ch][7:4]];
                stop_prev_r[ch] <= pin_s2_r[src_r[ch][3:0]];
            end
        end
    end

    // Run control per mode
    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!aresetn)
            begin
                run_r[ch] <= 1'b0;
            end
            else
            begin
                case (dicu_mode_e'(trig_r[ch][`DICU_TRIG_MODE_HI:`DICU_TRIG_MODE_LO]))
                    DICU_MODE_FREE: run_r[ch] <= 1'b1;
                    DICU_MODE_UNTIL_STOP:
                    begin
                        if (sw_clr[ch])
                            run_r[ch] <= 1'b1;
                        else if (stop_ev[ch] && !trig_r[ch][`DICU_TRIG_LATSP])
                            run_r[ch] <= 1'b0;
                    end
                    DICU_MODE_START_STOP:
                    begin
                        if (sw_clr[ch])
                            run_r[ch] <= 1'b0;
                        else if (stop_ev[ch] && !trig_r[ch][`DICU_TRIG_LATSP])
                            run_r[ch] <= 1'b0;
                        else if (start_ev[ch] && !trig_r[ch][`DICU_TRIG_LATST])
                            run_r[ch] <= 1'b1;
                    end
                    default: run_r[ch] <= 1'b0;
                endcase
            end
        end
    end

    // Counter, capture latch and high-byte freeze
    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!aresetn || sw_clr[ch])
            begin
                count_r[ch] <= 16'h0000;
            end
            else if (tick && run_r[ch])
            begin
                count_r[ch] <= count_r[ch] + 16'h0001;
            end
            if (!aresetn)
            begin
                latch_r[ch] <= 16'h0000;
                hi_shadow_r[ch] <= 8'h00;
            end
            else
            begin
                if (cap_ev[ch])
                    latch_r[ch] <= count_r[ch];
                if (lo_rd[ch])
                    hi_shadow_r[ch] <= latch_r[ch][15:8];
            end
        end
    end

    assign chan1_count = count_r[0];
    assign chan2_count = count_r[1];

    // Sticky flags; a new event wins over the clearing read
    always_ff @(posedge aclk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!aresetn)
            begin
                start_flag_r[ch] <= 1'b0;
                stop_flag_r[ch] <= 1'b0;
                roll_flag_r[ch] <= 1'b0;
            end
            else
            begin
                start_flag_r[ch] <= start_ev[ch] || (start_flag_r[ch] && !css_rd);
                stop_flag_r[ch] <= stop_ev[ch] || (stop_flag_r[ch] && !css_rd);
                roll_flag_r[ch] <= roll_ev[ch] || (roll_flag_r[ch] && !css_rd);
            end
        end
    end

    // =========================================================
    // Interrupt request
    // =========================================================
    assign irq_set = (start_ev[1] && irq_en_r[5]) || (stop_ev[1] && irq_en_r[4])
        || (start_ev[0] && irq_en_r[3]) || (stop_ev[0] && irq_en_r[2])
        || (roll_ev[1] && irq_en_r[1]) || (roll_ev[0] && irq_en_r[0]);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_pend_r <= 1'b0;
        end
        else
        begin
            irq_pend_r <= irq_set || (irq_pend_r && !css_rd);
        end
    end

    assign capture_irq_req = irq_pend_r && prio_r != 2'h0;
    assign capture_irq_level = prio_r;

    // =========================================================
    // Assertions
    // =========================================================
    default clocking dicu_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_flag_on_start: assert property (start_ev[0] |=> start_flag_r[0])
        else $error("start flag not set");
    chk_roll_wrap: assert property (roll_ev[0] |=> count_r[0] == 16'h0000 && roll_flag_r[0])
        else $error("rollover not flagged");
    chk_read_clears_irq: assert property (css_rd && !irq_set |=> !irq_pend_r)
        else $error("status read left request pending");
    chk_set_beats_clear: assert property (css_rd && irq_set |=> irq_pend_r)
        else $error("event lost against clearing read");
    chk_hi_freeze: assert property (lo_rd[0] |=> hi_shadow_r[0] == $past(latch_r[0][15:8]))
        else $error("high byte not frozen");
    chk_sw_clear: assert property (sw_clr[0] |=> count_r[0] == 16'h0000)
        else $error("software clear ignored");
    chk_count_step: assert property (tick && run_r[0] && !sw_clr[0]
        |=> count_r[0] == $past(count_r[0]) + 16'h0001)
        else $error("counter did not advance");
    chk_count_hold: assert property (!tick && !sw_clr[0] |=> $stable(count_r[0]))
        else $error("counter moved without tick");
    chk_latch_value: assert property (cap_ev[1] |=> latch_r[1] == $past(count_r[1]))
        else $error("capture latched wrong count");
    chk_tick_spacing: assert property (tick && $stable(presc_r) |=> !tick)
        else $error("ticks back to back");
endmodule : dicu_top

// File: dv/dicu_pin_src.sv
// Model of the external signals on the capture pins.
// Assumes one bench process calls span at a time, right after a clock edge.
module dicu_pin_src (
    input wire logic aclk,
    output logic [15:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================
    // Pin stimulus
    initial pins = 16'h0000;

    // Start edge on pin a, stop edge on pin b after hold clocks
    task automatic span(input int a, input int b, input int hold);
        @(posedge aclk);
        pins[a] <= 1'h1;
        repeat (hold) @(posedge aclk);
        if (a == b)
            pins[a] <= 1'h0;
        else
            pins[b] <= 1'h1;
        repeat (hold) @(posedge aclk);
        pins <= 16'h0000;
    endtask : span
endmodule : dicu_pin_src

// File: dv/testbench.sv
// Self-checking bench of the capture unit over its register bus.
// Assumes byte address = 4 * index and prescale at byte 0x180.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================
    // Signals
    localparam int LIMIT = 20000;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, capture_irq_level;
    logic [31:0] s_axi_rdata;
    logic [15:0] capture_pins;
    logic capture_irq_req, capture_tick;
    logic [1:0] wresp;
    logic [15:0] chan1_count, chan2_count;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int pre[3] = '{0, 1, 255};

`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s exp %h got %h", what, exp, got); end end

    always #5 aclk = ~aclk;

    dicu_top #(.ADDR_W(12)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .capture_pins, .capture_irq_req, .capture_irq_level,
        .capture_tick, .chan1_count, .chan2_count
    );

    dicu_pin_src src (.aclk(aclk), .pins(capture_pins));

    // ========================================
    // Bus tasks, entered just after a rising edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            if (tb) wresp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) s_axi_bready <= 1'h0;
        end
        while (!tb);
        // One edge between calls, so no strobe is set twice in a step
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        logic ta, tr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
            if (tr) s_axi_rready <= 1'h0;
        end
        while (!tr);
        @(posedge aclk);
    endtask : rd

    // Clocks between two counting ticks
    task automatic gap(output int g);
        repeat (2)
        begin
            g = 0;
            do
            begin
                @(negedge aclk);
                g++;
            end
            while (capture_tick !== 1'h1);
        end
        @(posedge aclk);
    endtask : gap

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ========================================
    // Test sequence
    initial
    begin
        logic [7:0] v, lo, hi;
        logic [1:0] r;
        logic [11:0] base;
        int g;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(12'h158, v, r);
        `CHK("css_reset", 8'h00, v);
        `CHK("prio_reset", 2'h0, capture_irq_level);
        rd(12'h200, v, r);
        `CHK("unmapped_resp", 2'h2, r);
        `CHK("unmapped_data", 8'h00, v);
        wr(12'h200, 8'h00);
        `CHK("unmapped_bresp", 2'h2, wresp);
        for (int i = 0; i < 3; i++)
        begin
            wr(12'h180, 8'(pre[i]));
            gap(g);
            `CHK("tick_gap", 2 * (pre[i] + 1), g);
        end
        wr(12'h180, 8'h01);
        wr(12'h15c, 8'h02);
        `CHK("prio_bresp", 2'h0, wresp);
        `CHK("prio_level", 2'h2, capture_irq_level);
        // Free run, latch on either start edge, every pin in turn
        wr(12'h164, 8'h00);
        wr(12'h160, 8'h72);
        for (int p = 0; p < 16; p++)
        begin
            wr(12'h164, {p[3:0], 4'h0});
            rd(12'h158, v, r);
            src.span(p, p, 12);
            repeat (20) @(posedge aclk);
            rd(12'h158, v, r);
            `CHK("pin_start", 8'h20, v);
        end
        // Pulse width: shared pin on channel 1, two pins on channel 2
        for (int c = 0; c < 2; c++)
        begin
            base = (c == 1) ? 12'h170 : 12'h160;
            wr(base + 12'h004, (c == 1) ? 8'h59 : 8'h33);
            wr(base, (c == 1) ? 8'hd5 : 8'hd9);
            wr(12'h158, 8'hf0 | (8'h01 << c));
            `CHK("live_count", 16'h0000, (c == 1) ? chan2_count : chan1_count);
            rd(12'h158, v, r);
            src.span((c == 1) ? 5 : 3, (c == 1) ? 9 : 3, 160);
            repeat (30) @(posedge aclk);
            `CHK("irq_set", 1'h1, capture_irq_req);
            rd(12'h158, v, r);
            `CHK("css_flags", (c == 1) ? 8'hc0 : 8'h30, v);
            repeat (2) @(posedge aclk);
            `CHK("irq_clear", 1'h0, capture_irq_req);
            rd(base + 12'h008, lo, r);
            rd(base + 12'h00c, hi, r);
            `CHK("width", 1'h1, {hi, lo} >= 16'h0026 && {hi, lo} <= 16'h002a);
        end
        tally_and_finish();
    end
endmodule : testbench
